// [i2cb_host.sv]
// i2c host sequencer with baud generator and bus collision detection, apb register access
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "i2cb_defines.svh"
module i2cb_host
    import i2cb_pkg::*;
(
    // system clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // link clock
    input wire logic i_link_clk,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    // open-drain pins
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_scl_i,
    output logic o_scl_o,
    output logic o_scl_oe
);
    i2cb_apb_t ar;
    i2cb_apb_t an;
    i2cb_link_t lr;
    i2cb_link_t ln;
    logic done_edge;
    logic coll_edge;
    logic wr_done;
    logic req_edge;

    // register read mux, unmapped addresses read zero
    function automatic logic [31:0] rd_word(input i2cb_apb_t s, input logic [7:0] a,
                                            input logic lock);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `I2CB_OFF_RELOAD: w[7:0] = s.reload;
            `I2CB_OFF_TXBUF: w[7:0] = s.txbuf;
            `I2CB_OFF_SEQ: w[2:0] = s.seq;
            `I2CB_OFF_STAT:
            begin
                w[`I2CB_ST_COLL] = s.coll;
                w[`I2CB_ST_EVT] = s.evt;
                w[`I2CB_ST_BUSY] = s.busy;
                w[`I2CB_ST_WCOL] = s.wcol;
                w[`I2CB_ST_LOCK] = lock;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == `I2CB_OFF_RELOAD) || (a == `I2CB_OFF_TXBUF) ||
               (a == `I2CB_OFF_SEQ) || (a == `I2CB_OFF_STAT);
    endfunction

    // abort: release both lines, go idle, refuse to drive until a start
    function automatic i2cb_link_t collide(input i2cb_link_t s);
        i2cb_link_t t;
        t = s;
        t.sda_oe = 1'b0;
        t.scl_oe = 1'b0;
        t.st = L_IDLE;
        t.locked = 1'b1;
        t.coll_tog = ~s.coll_tog;
        t.done_tog = ~s.done_tog;
        return t;
    endfunction

    // end of a sequence: go idle, the counter is left to run down to zero, lines keep their level
    function automatic i2cb_link_t finish(input i2cb_link_t s);
        i2cb_link_t t;
        t = s;
        t.st = L_IDLE;
        t.done_tog = ~s.done_tog;
        return t;
    endfunction

    function automatic logic expired(input logic [7:0] c);
        return c == 8'h00;
    endfunction

    // register-bus side next state
    always_comb
    begin
        an = ar;
        an.pready = 1'b0;
        an.pslverr = 1'b0;
        an.done_s1 = lr.done_tog;
        an.done_s2 = ar.done_s1;
        an.done_s3 = ar.done_s2;
        an.coll_s1 = lr.coll_tog;
        an.coll_s2 = ar.coll_s1;
        an.coll_s3 = ar.coll_s2;
        done_edge = ar.done_s2 ^ ar.done_s3;
        coll_edge = ar.coll_s2 ^ ar.coll_s3;
        wr_done = i_psel && i_penable && ar.pready && i_pwrite;
        // first access cycle prepares the answer, the second completes it
        if (i_psel && i_penable && !ar.pready)
        begin
            an.pready = 1'b1;
            an.prdata = rd_word(ar, i_paddr, lr.locked);
            an.pslverr = !mapped(i_paddr);
        end
        if (done_edge)
        begin
            an.busy = 1'b0;
            an.seq = 3'h0;
            an.evt = 1'b1;
        end
        if (coll_edge)
        begin
            an.seq = 3'h0;
        end
        if (wr_done)
        begin
            case (i_paddr)
                `I2CB_OFF_RELOAD: an.reload = i_pwdata[7:0];
                `I2CB_OFF_TXBUF:
                begin
                    // a write during a running sequence is dropped and flagged
                    if (an.busy)
                        an.wcol = 1'b1;
                    else
                    begin
                        an.txbuf = i_pwdata[7:0];
                        an.cmd = CMD_TX;
                        an.busy = 1'b1;
                        an.req_tog = ~ar.req_tog;
                    end
                end
                `I2CB_OFF_SEQ: an.seq = an.seq | i_pwdata[2:0];
                `I2CB_OFF_STAT:
                begin
                    // write one to clear, but a same-cycle set below still wins
                    if (i_pwdata[`I2CB_ST_COLL])
                        an.coll = 1'b0;
                    if (i_pwdata[`I2CB_ST_EVT])
                        an.evt = 1'b0;
                    if (i_pwdata[`I2CB_ST_WCOL])
                        an.wcol = 1'b0;
                end
                default: an.coll = an.coll;
            endcase
        end
        if (coll_edge)
            an.coll = 1'b1;
        if (done_edge)
            an.evt = 1'b1;
        // one pending sequence at a time, start first
        if (!an.busy && (an.seq != 3'h0))
        begin
            an.busy = 1'b1;
            an.req_tog = ~ar.req_tog;
            if (an.seq[`I2CB_SEQ_START])
                an.cmd = CMD_START;
            else if (an.seq[`I2CB_SEQ_RSTART])
                an.cmd = CMD_RSTART;
            else
                an.cmd = CMD_STOP;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ar <= '{reload: `I2CB_RELOAD_RST, cmd: CMD_START, default: '0};
        else
            ar <= an;
    end

    // link side next state; command fields are held steady while busy
    always_comb
    begin
        ln = lr;
        ln.sda_s1 = i_sda_i;
        ln.sda_s = lr.sda_s1;
        ln.scl_s1 = i_scl_i;
        ln.scl_s = lr.scl_s1;
        ln.req_s1 = ar.req_tog;
        ln.req_s2 = lr.req_s1;
        ln.req_s3 = lr.req_s2;
        ln.drv_lvl = 1'b0;
        req_edge = lr.req_s2 ^ lr.req_s3;
        if (!expired(lr.cnt))
            ln.cnt = lr.cnt - 8'h01;
        case (lr.st)
            L_IDLE:
            begin
                if (req_edge)
                begin
                    ln.reload = ar.reload;
                    ln.cnt = ar.reload;
                    if (ar.cmd == CMD_START)
                    begin
                        ln.locked = 1'b0;
                        ln.st = L_ST_CHK;
                    end
                    else if (lr.locked)
                        ln = finish(ln);
                    else if (ar.cmd == CMD_RSTART)
                        ln.st = L_RS_REL;
                    else if (ar.cmd == CMD_STOP)
                        ln.st = L_SP_SDALO;
                    else
                    begin
                        ln.shift = {ar.txbuf, 1'b1};
                        ln.bits = `I2CB_TX_BITS;
                        ln.st = L_TX_LO;
                    end
                end
            end
            L_ST_CHK:
            begin
                ln.sda_oe = 1'b0;
                ln.scl_oe = 1'b0;
                if (!lr.sda_s || !lr.scl_s)
                    ln = collide(ln);
                else
                begin
                    ln.cnt = lr.reload;
                    ln.st = L_RS_CNT2;
                end
            end
            L_RS_REL:
            begin
                ln.sda_oe = 1'b0;
                if (lr.sda_s)
                begin
                    ln.cnt = lr.reload;
                    ln.st = L_RS_CNT1;
                end
            end
            L_RS_CNT1:
            begin
                if (expired(lr.cnt))
                begin
                    ln.scl_oe = 1'b0;
                    ln.st = L_RS_SCLHI;
                end
            end
            L_RS_SCLHI:
            begin
                if (lr.scl_s)
                begin
                    if (!lr.sda_s)
                        ln = collide(ln);
                    else
                    begin
                        ln.cnt = lr.reload;
                        ln.st = L_RS_CNT2;
                    end
                end
            end
            L_RS_CNT2:
            begin
                // another host pulling sda first is normal arbitration, not a fault
                if (!lr.scl_s)
                    ln = collide(ln);
                else if (expired(lr.cnt))
                begin
                    ln.sda_oe = 1'b1;
                    ln.cnt = lr.reload;
                    ln.st = L_RS_CNT3;
                end
            end
            L_RS_CNT3:
            begin
                if (expired(lr.cnt))
                begin
                    ln.scl_oe = 1'b1;
                    ln = finish(ln);
                end
            end
            L_SP_SDALO:
            begin
                ln.sda_oe = 1'b1;
                if (!lr.sda_s && lr.sda_oe)
                begin
                    ln.scl_oe = 1'b0;
                    ln.st = L_SP_SCLHI;
                end
            end
            L_SP_SCLHI:
            begin
                // clock stretching by a client simply holds us here
                if (lr.scl_s)
                begin
                    ln.cnt = lr.reload;
                    ln.st = L_SP_CNT1;
                end
            end
            L_SP_CNT1:
            begin
                if (!lr.scl_s)
                    ln = collide(ln);
                else if (expired(lr.cnt))
                begin
                    ln.sda_oe = 1'b0;
                    ln.cnt = lr.reload;
                    ln.st = L_SP_CNT2;
                end
            end
            L_SP_CNT2:
            begin
                if (!lr.scl_s && !lr.sda_s)
                    ln = collide(ln);
                else if (expired(lr.cnt))
                begin
                    if (!lr.sda_s)
                        ln = collide(ln);
                    else
                        ln = finish(ln);
                end
            end
            L_TX_LO:
            begin
                ln.scl_oe = 1'b1;
                ln.sda_oe = !lr.shift[8];
                if (expired(lr.cnt))
                begin
                    ln.scl_oe = 1'b0;
                    ln.st = L_TX_HIW;
                end
            end
            L_TX_HIW:
            begin
                if (lr.scl_s)
                begin
                    ln.cnt = lr.reload;
                    ln.st = L_TX_HI;
                end
            end
            L_TX_HI:
            begin
                if (expired(lr.cnt))
                begin
                    ln.scl_oe = 1'b1;
                    ln.shift = {lr.shift[7:0], 1'b1};
                    ln.bits = lr.bits - 4'h1;
                    ln.cnt = lr.reload;
                    if (lr.bits == 4'h1)
                        ln = finish(ln);
                    else
                        ln.st = L_TX_LO;
                end
            end
            default: ln.st = L_IDLE;
        endcase
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            lr <= '{st: L_IDLE, reload: `I2CB_RELOAD_RST, sda_s1: 1'b1, sda_s: 1'b1,
                    scl_s1: 1'b1, scl_s: 1'b1, default: '0};
        else
            lr <= ln;
    end

    // outputs straight from the state registers
    assign o_pready = ar.pready;
    assign o_pslverr = ar.pslverr;
    assign o_prdata = ar.prdata;
    assign o_sda_o = lr.drv_lvl;
    assign o_scl_o = lr.drv_lvl;
    assign o_sda_oe = lr.sda_oe;
    assign o_scl_oe = lr.scl_oe;

    property p_rs_sda_low;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (lr.st == L_RS_SCLHI && lr.scl_s && !lr.sda_s) |=> ($changed(lr.coll_tog) && !lr.sda_oe);
    endproperty
    a_rs_sda_low: assert property (p_rs_sda_low) else $error("rs sda low missed");

    property p_rs_scl_fall;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (lr.st == L_RS_CNT2 && !lr.scl_s) |=> ($changed(lr.coll_tog) && lr.st == L_IDLE);
    endproperty
    a_rs_scl_fall: assert property (p_rs_scl_fall) else $error("rs scl fall missed");

    property p_rs_sda_fall_ok;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (lr.st == L_RS_CNT2 && lr.scl_s && !lr.sda_s) |=> $stable(lr.coll_tog);
    endproperty
    a_rs_sda_fall_ok: assert property (p_rs_sda_fall_ok) else $error("false collision");

    property p_rs_reload;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (lr.st == L_RS_SCLHI && lr.scl_s && lr.sda_s) |=> (lr.cnt == lr.reload);
    endproperty
    a_rs_reload: assert property (p_rs_reload) else $error("counter not reloaded");

    property p_rs_end;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (lr.st == L_RS_CNT2 && lr.scl_s && expired(lr.cnt)) |=> lr.sda_oe ##[1:257]
        (lr.scl_oe && lr.st == L_IDLE);
    endproperty
    a_rs_end: assert property (p_rs_end) else $error("repeated start not completed");

    property p_stop_sda;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (lr.st == L_SP_CNT2 && expired(lr.cnt) && !lr.sda_s) |=> $changed(lr.coll_tog);
    endproperty
    a_stop_sda: assert property (p_stop_sda) else $error("stop sda low missed");

    property p_stop_scl;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (lr.st == L_SP_CNT1 && !lr.scl_s) |=> ($changed(lr.coll_tog) && !lr.scl_oe);
    endproperty
    a_stop_scl: assert property (p_stop_scl) else $error("stop scl low missed");

    property p_locked_quiet;
        @(posedge i_link_clk) disable iff (!i_rst_n)
        (lr.locked && lr.st == L_IDLE) |=> (!lr.sda_oe && !lr.scl_oe);
    endproperty
    a_locked_quiet: assert property (p_locked_quiet) else $error("drove while locked");

    property p_flag_set;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (ar.coll_s2 != ar.coll_s3) |=> (ar.coll && ar.seq == 3'h0);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("collision flag not set");
endmodule
`default_nettype wire

// [i2cb_defines.svh]
// register offsets, field positions and reset values of the collision-aware i2c host
`ifndef I2CB_DEFINES_SVH
`define I2CB_DEFINES_SVH
`define I2CB_OFF_RELOAD 8'h00
`define I2CB_OFF_TXBUF 8'h04
`define I2CB_OFF_SEQ 8'h08
`define I2CB_OFF_STAT 8'h0c
`define I2CB_SEQ_START 0
`define I2CB_SEQ_RSTART 1
`define I2CB_SEQ_STOP 2
`define I2CB_ST_COLL 0
`define I2CB_ST_EVT 1
`define I2CB_ST_BUSY 2
`define I2CB_ST_WCOL 3
`define I2CB_ST_LOCK 4
`define I2CB_RELOAD_RST 8'h13
`define I2CB_TX_BITS 4'h9
`endif

// [i2cb_pkg.sv]
// types shared by the collision-aware i2c host
package i2cb_pkg;
    typedef enum logic [1:0] {CMD_START, CMD_RSTART, CMD_STOP, CMD_TX} i2cb_cmd_t;
    typedef enum logic [3:0] {
        L_IDLE, L_ST_CHK, L_RS_REL, L_RS_CNT1, L_RS_SCLHI, L_RS_CNT2, L_RS_CNT3,
        L_SP_SDALO, L_SP_SCLHI, L_SP_CNT1, L_SP_CNT2, L_TX_LO, L_TX_HIW, L_TX_HI
    } i2cb_lstate_t;
    // register-bus side state
    typedef struct packed {
        logic [7:0] reload;
        logic [7:0] txbuf;
        logic [2:0] seq;
        logic coll;
        logic evt;
        logic wcol;
        logic busy;
        logic req_tog;
        i2cb_cmd_t cmd;
        logic done_s1;
        logic done_s2;
        logic done_s3;
        logic coll_s1;
        logic coll_s2;
        logic coll_s3;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } i2cb_apb_t;
    // link side state
    typedef struct packed {
        i2cb_lstate_t st;
        logic [7:0] cnt;
        logic [7:0] reload;
        logic [8:0] shift;
        logic [3:0] bits;
        logic locked;
        logic sda_oe;
        logic scl_oe;
        logic drv_lvl;
        logic sda_s1;
        logic sda_s;
        logic scl_s1;
        logic scl_s;
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic done_tog;
        logic coll_tog;
    } i2cb_link_t;
endpackage

// [i2cb_bus_model.sv]
// far-side bus model: pull-ups plus another host that may pull either line low
`timescale 1ns/1ps
`default_nettype none
module i2cb_bus_model
(
    // link clock
    input wire logic i_link_clk,
    // behaviour chosen by the bench
    input wire logic [2:0] i_mode,
    // host open-drain enables
    input wire logic i_sda_oe,
    input wire logic i_scl_oe,
    // resolved line levels
    output logic o_sda,
    output logic o_scl
);
    logic sda_pull = 1'b0;
    logic scl_pull = 1'b0;
    logic scl_prev = 1'b1;
    logic [3:0] wait_cnt = 4'h0;
    // wired-and with pull-ups: a line nobody pulls reads high
    assign o_sda = ~(i_sda_oe | sda_pull);
    assign o_scl = ~(i_scl_oe | scl_pull);
    // mode 1: sda low after it stood high with scl low for a while
    // mode 2: scl low shortly after it rose; mode 3: sda held low; mode 0 lets go
    // mode 4: sda low a while after both lines stood high, a rival's early start
    // the pull stays on once taken, as a real rival host would not back off
    always_ff @(posedge i_link_clk)
    begin
        scl_prev <= o_scl;
        if (i_mode == 3'h0)
        begin
            sda_pull <= 1'b0;
            scl_pull <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else if (i_mode == 3'h3)
            sda_pull <= 1'b1;
        else if (wait_cnt == 4'h6)
        begin
            sda_pull <= (i_mode == 3'h1) || (i_mode == 3'h4);
            scl_pull <= (i_mode == 3'h2);
        end
        else if ((i_mode == 3'h1 && o_sda && !o_scl) ||
                 (i_mode == 3'h4 && o_sda && o_scl) ||
                 (i_mode == 3'h2 && ((o_scl && !scl_prev) || wait_cnt != 4'h0)))
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule
`default_nettype wire

// [i2cb_host_tb_top.sv]
// self-checking bench for the collision-aware i2c host
`timescale 1ns/1ps
`default_nettype none
`include "i2cb_defines.svh"
module i2cb_host_tb_top;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sda_oe;
    logic scl_oe;
    logic sda_w;
    logic scl_w;
    logic sda_o;
    logic scl_o;
    logic [2:0] mode = 3'h0;
    logic [31:0] rd;
    logic er;
    logic watch_quiet = 1'b0;
    logic [8:0] cap = 9'h000;
    int quiet_hits = 0;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    // system clock, 50 ns
    always #25 sys_clk = ~sys_clk;
    // link clock, 12 ns, offset by 3 ns; the two rising edges still line up every 300 ns
    initial
    begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    i2cb_host DUT (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_link_clk(link_clk),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
        .i_sda_i(sda_w), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
        .i_scl_i(scl_w), .o_scl_o(scl_o), .o_scl_oe(scl_oe));
    i2cb_bus_model far_side (.i_link_clk(link_clk), .i_mode(mode), .i_sda_oe(sda_oe),
        .i_scl_oe(scl_oe), .o_sda(sda_w), .o_scl(scl_w));
    // a locked-out host must leave both wires alone
    always @(posedge link_clk)
        if (watch_quiet && (sda_oe || scl_oe))
            quiet_hits++;
    // bits as a receiver sees them at each scl rise
    always @(posedge scl_w)
        cap <= {cap[7:0], sda_w};
    // hang guard, well above the several hundred cycles the run needs; it ends every wait
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // one apb transfer; the access phase is held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
        apb(1'b1, a, d);
    end
    endtask
    task automatic rdr(input logic [7:0] a);
    begin
        apb(1'b0, a, 32'h0);
    end
    endtask
    // clear flags, request one sequence, poll until hardware clears its bit
    task automatic seq(input int b);
    begin
        wr(`I2CB_OFF_STAT, 32'h1b);
        wr(`I2CB_OFF_SEQ, 32'h1 << b);
        rdr(`I2CB_OFF_SEQ);
        while (rd[2:0] !== 3'h0)
            rdr(`I2CB_OFF_SEQ);
        repeat (4) @(posedge sys_clk);
    end
    endtask
    task automatic expect_state(input logic [1:0] oe, input logic [7:0] st);
    begin
        rdr(`I2CB_OFF_STAT);
        check(rd, {24'h0, st});
        check({30'h0, sda_oe, scl_oe}, {30'h0, oe});
        check({30'h0, sda_o, scl_o}, 32'h0);
    end
    endtask
    task automatic t_regs();
    begin
        rdr(`I2CB_OFF_RELOAD);
        check(rd, {24'h0, `I2CB_RELOAD_RST});
        rdr(8'h10);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        expect_state(2'h0, 8'h00);
        $display("test regs done");
    end
    endtask
    task automatic t_good();
    begin
        seq(`I2CB_SEQ_START);
        expect_state(2'h3, 8'h02);
        seq(`I2CB_SEQ_RSTART);
        expect_state(2'h3, 8'h02);
        seq(`I2CB_SEQ_STOP);
        expect_state(2'h0, 8'h02);
        $display("test clean sequences done");
    end
    endtask
    // rival pulls sda during the second repeated start count: arbitration, not a fault
    task automatic t_rs_rival();
    begin
        seq(`I2CB_SEQ_START);
        mode <= 3'h4;
        seq(`I2CB_SEQ_RSTART);
        expect_state(2'h3, 8'h02);
        mode <= 3'h0;
        seq(`I2CB_SEQ_STOP);
        expect_state(2'h0, 8'h02);
        $display("test rival repeated start done");
    end
    endtask
    // rival host acts during sequence b; afterwards a stop must not touch the wires
    task automatic coll_case(input logic [2:0] m, input int b);
    begin
        seq(`I2CB_SEQ_START);
        mode <= m;
        seq(b);
        expect_state(2'h0, 8'h13);
        mode <= 3'h0;
        watch_quiet <= 1'b1;
        seq(`I2CB_SEQ_STOP);
        watch_quiet <= 1'b0;
        check(quiet_hits, 0);
        $display("test collision case done");
    end
    endtask
    task automatic t_tx();
    begin
        logic [1:0] snap;
        wr(`I2CB_OFF_RELOAD, 32'h03);
        rdr(`I2CB_OFF_RELOAD);
        check(rd, 32'h03);
        seq(`I2CB_SEQ_START);
        wr(`I2CB_OFF_TXBUF, 32'ha5);
        wr(`I2CB_OFF_TXBUF, 32'h5a);
        rdr(`I2CB_OFF_STAT);
        check({30'h0, rd[3:2]}, 32'h3);
        while (rd[2] !== 1'b0)
            rdr(`I2CB_OFF_STAT);
        snap = {sda_oe, scl_oe};
        repeat (40) @(posedge link_clk);
        check({30'h0, sda_oe, scl_oe}, {30'h0, snap});
        check({23'h0, cap}, {23'h0, 8'ha5, 1'b1});
        seq(`I2CB_SEQ_STOP);
        expect_state(2'h0, 8'h02);
        $display("test transmit done");
    end
    endtask
    task automatic report_and_stop();
    begin
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // reset, then the scenarios in order
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_good();
        t_rs_rival();
        coll_case(3'h1, `I2CB_SEQ_RSTART);
        coll_case(3'h2, `I2CB_SEQ_RSTART);
        coll_case(3'h3, `I2CB_SEQ_STOP);
        coll_case(3'h2, `I2CB_SEQ_STOP);
        t_tx();
        report_and_stop();
    end
endmodule
`default_nettype wire
